// ### mcrb_chk.sv
/* checker of the bank's ports.
   bound from the bench top; one clock, sync active-high reset. */
`timescale 1ns/1ps
module mcrb_chk (
	input wire logic         core_clk, reset, soft_restart, load_busy, rx_hdr_valid,
	input wire logic         rx_accept, rx_discard, cmd_valid, cmd_match,
	input wire logic [4:0]   rd_addr,
	input wire logic [7:0]   rd_data, rx_dest_addr, cmd_addr, tx_src_addr, drop_addr,
	input wire logic [7:0]   headerless_dest, special_mode,
	input wire logic [15:0]  scramble_seed,
	input wire logic [223:0] active_cfg
);
	// ====================
	// port relations
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	busy_a: assert property (soft_restart |=> load_busy) else $error("no copy");
	hold_a: assert property (!load_busy |=> $stable(active_cfg)) else $error("early");
	accept_a: assert property (rx_hdr_valid && active_cfg[145:144] == 2'h0
		|=> rx_accept && !rx_discard) else $error("not accepted");
	discard_a: assert property (rx_hdr_valid && active_cfg[144]
		&& rx_dest_addr != tx_src_addr |=> rx_discard) else $error("not discarded");
	quiet_a: assert property (!rx_hdr_valid |=> !rx_accept && !rx_discard) else $error("pulse");
	group_a: assert property (cmd_valid && cmd_addr == active_cfg[15:8]
		|=> cmd_match) else $error("no match");
	outputs_a: assert property (tx_src_addr == active_cfg[7:0] && drop_addr == tx_src_addr
		&& {special_mode, headerless_dest} == active_cfg[31:16]) else $error("outputs");
	seed_a: assert property (scramble_seed == (active_cfg[47:40] >= 8'hF0 ? 16'hEFFF
		: active_cfg[47:32])) else $error("seed");
	unmapped_a: assert property (rd_addr > 5'h1B |=> rd_data == 8'h00) else $error("rd");
endmodule : mcrb_chk

// ### mcrb_config_bank.sv
/*
 * modem configuration register bank: stored (shadow) registers, active copy, address logic.
 * assumes the serial command parser drives wr_en/rd_addr on core_clk; headers are parallel.
 */
`timescale 1ns/1ps
// How it works
// RULE1: 28 registers load defaults at reset
// RULE2: writes take effect only after reset/restart; here reset reloads defaults and drops the writes, so only restart applies them
// RULE3: host keeps local address within 0-239
// RULE4: local address drives transmitted source field
// RULE5: destination check discards mismatched packets
// RULE6: local address also serves multidrop line
// RULE7: host keeps group address within 240-254
// RULE8: act on commands to group address
// RULE9: destination register used only mode five; here the source check uses it in any mode
// RULE10: special setting selects special modes
// RULE11: two code bytes form one identifier
// RULE12: host keeps high code byte below 240
// RULE13: high byte >=240 forces FFH/EFH code
// RULE14: code seeds scrambler and descrambler
// RULE15: integrator programs same code system-wide
// RULE16: comm setting bit0 enables destination check
// RULE17: 8-bit registers; reserved hold defaults
// RULE18: shadow copied to active on restart
module mcrb_config_bank
	import mcrb_pkg::*;
(
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     wr_en,
	input  wire logic [mcrb_pkg::ADDR_W-1:0] wr_addr,
	input  wire logic [mcrb_pkg::REG_W-1:0]  wr_data,
	input  wire logic [mcrb_pkg::ADDR_W-1:0] rd_addr,
	output logic      [mcrb_pkg::REG_W-1:0]  rd_data,
	input  wire logic                     soft_restart,
	input  wire logic [7:0]               rx_dest_addr,
	input  wire logic [7:0]               rx_src_addr,
	input  wire logic                     rx_hdr_valid,
	output logic                          rx_accept,
	output logic                          rx_discard,
	input  wire logic [7:0]               cmd_addr,
	input  wire logic                     cmd_valid,
	output logic                          cmd_match,
	output logic      [7:0]               tx_src_addr,
	output logic      [7:0]               drop_addr,
	output logic      [7:0]               headerless_dest,
	output logic      [7:0]               special_mode,
	output logic      [15:0]              scramble_seed,
	output logic                          load_busy,
	output logic      [NUM_REGS*REG_W-1:0] active_cfg
);
	import mcrb_pkg::*;

	// ==========================================
	// storage
	logic [7:0]  store_ff   [NUM_REGS];
	logic [7:0]  nxt_store  [NUM_REGS];
	logic [7:0]  active_ff  [NUM_REGS];
	logic [7:0]  nxt_active [NUM_REGS];

	mcrb_state_e state_ff;
	mcrb_state_e nxt_state;
	logic        load_now;

	logic [7:0]  rd_data_ff;
	logic [7:0]  nxt_rd_data;
	logic        accept_ff;
	logic        nxt_accept;
	logic        discard_ff;
	logic        nxt_discard;
	logic        cmd_ff;
	logic        nxt_cmd;

	logic [15:0] seed_ff;
	logic [15:0] nxt_seed;
	logic [7:0]  code_high;
	logic [7:0]  code_low;

	logic        dest_check_on;
	logic        src_check_on;
	logic [7:0]  local_addr;
	logic [7:0]  group_addr;
	logic [7:0]  peer_addr;

	// ==========================================
	// stored copy: host writes land here
	always_comb begin
		for (int i = 0; i < NUM_REGS; i++) begin
			nxt_store[i] = store_ff[i];
		end
		// reserved and unmapped offsets fall through, so their writes vanish
		if (wr_en) begin // RULE2
			// addresses
			if (wr_addr == OFF_LOCAL_STATION) begin
				nxt_store[OFF_LOCAL_STATION] = wr_data;
			end else if (wr_addr == OFF_GROUP_ADDR) begin
				nxt_store[OFF_GROUP_ADDR] = wr_data;
			end else if (wr_addr == OFF_DEST_ADDR) begin
				nxt_store[OFF_DEST_ADDR] = wr_data;
			end else if (wr_addr == OFF_SPECIAL) begin
				nxt_store[OFF_SPECIAL] = wr_data;
			// system code
			end else if (wr_addr == OFF_SYS_CODE_LOW) begin
				nxt_store[OFF_SYS_CODE_LOW] = wr_data;
			end else if (wr_addr == OFF_SYS_CODE_HIGH) begin
				nxt_store[OFF_SYS_CODE_HIGH] = wr_data;
			// radio and timing
			end else if (wr_addr == OFF_FREQ_GROUP) begin
				nxt_store[OFF_FREQ_GROUP] = wr_data;
			end else if (wr_addr == OFF_PKT_INTERVAL) begin
				nxt_store[OFF_PKT_INTERVAL] = wr_data;
			end else if (wr_addr == OFF_CMD_HEADER) begin
				nxt_store[OFF_CMD_HEADER] = wr_data;
			end else if (wr_addr == OFF_RETX_COUNT) begin
				nxt_store[OFF_RETX_COUNT] = wr_data;
			end else if (wr_addr == OFF_ROAM_THRESH) begin
				nxt_store[OFF_ROAM_THRESH] = wr_data;
			end else if (wr_addr == OFF_RX_OUT_GAP) begin
				nxt_store[OFF_RX_OUT_GAP] = wr_data;
			end else if (wr_addr == OFF_CMD_RECOG) begin
				nxt_store[OFF_CMD_RECOG] = wr_data;
			end else if (wr_addr == OFF_CMD_TIMEOUT) begin
				nxt_store[OFF_CMD_TIMEOUT] = wr_data;
			// link and mode settings
			end else if (wr_addr == OFF_COMM_SET_ONE) begin
				nxt_store[OFF_COMM_SET_ONE] = wr_data;
			end else if (wr_addr == OFF_COMM_SET_TWO) begin
				nxt_store[OFF_COMM_SET_TWO] = wr_data;
			end else if (wr_addr == OFF_SERIAL_ONE) begin
				nxt_store[OFF_SERIAL_ONE] = wr_data;
			end else if (wr_addr == OFF_SERIAL_TWO) begin
				nxt_store[OFF_SERIAL_TWO] = wr_data;
			end else if (wr_addr == OFF_SERIAL_THREE) begin
				nxt_store[OFF_SERIAL_THREE] = wr_data;
			end else if (wr_addr == OFF_SERIAL_FOUR) begin
				nxt_store[OFF_SERIAL_FOUR] = wr_data;
			end else if (wr_addr == OFF_MISC) begin
				nxt_store[OFF_MISC] = wr_data;
			end else if (wr_addr == OFF_LOW_POWER) begin
				nxt_store[OFF_LOW_POWER] = wr_data;
			end else if (wr_addr == OFF_BAND) begin
				nxt_store[OFF_BAND] = wr_data;
			end // RULE17
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				store_ff[i] <= REG_DEFAULT[i]; // RULE1
			end
		end else begin
			for (int i = 0; i < NUM_REGS; i++) begin
				store_ff[i] <= nxt_store[i];
			end
		end
	end

	// ==========================================
	// restart sequencer and active copy
	assign load_now = (state_ff == MCRB_LOAD);

	always_comb begin
		nxt_state = MCRB_RUN;
		for (int i = 0; i < NUM_REGS; i++) begin
			nxt_active[i] = active_ff[i];
		end
		case (state_ff)
			MCRB_RUN: begin
				if (soft_restart) begin
					nxt_state = MCRB_LOAD;
				end
			end
			MCRB_LOAD: begin
				// one-cycle copy; a write in this cycle waits for the next restart
				for (int i = 0; i < NUM_REGS; i++) begin
					nxt_active[i] = store_ff[i]; // RULE18 RULE2
				end
				if (soft_restart) begin
					nxt_state = MCRB_LOAD;
				end
			end
			default: begin
				nxt_state = MCRB_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_ff <= MCRB_RUN;
			for (int i = 0; i < NUM_REGS; i++) begin
				active_ff[i] <= REG_DEFAULT[i]; // RULE1 RULE2
			end
		end else begin
			state_ff <= nxt_state;
			for (int i = 0; i < NUM_REGS; i++) begin
				active_ff[i] <= nxt_active[i];
			end
		end
	end

	// ==========================================
	// system code seed, follows the active copy edge for edge
	assign code_high = nxt_active[OFF_SYS_CODE_HIGH];
	assign code_low  = nxt_active[OFF_SYS_CODE_LOW];

	always_comb begin
		// out-of-range high byte would alias another system, so clamp
		if (code_high >= CODE_HIGH_LIMIT) begin // RULE13
			nxt_seed = {CODE_HIGH_CLAMP, CODE_LOW_CLAMP};
		end else begin
			nxt_seed = {code_high, code_low}; // RULE11
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			seed_ff <= {REG_DEFAULT[OFF_SYS_CODE_HIGH], REG_DEFAULT[OFF_SYS_CODE_LOW]};
		end else begin
			seed_ff <= nxt_seed;
		end
	end

	// ==========================================
	// readback from the stored copy
	always_comb begin
		// addresses
		if (rd_addr == OFF_LOCAL_STATION) begin
			nxt_rd_data = store_ff[OFF_LOCAL_STATION];
		end else if (rd_addr == OFF_GROUP_ADDR) begin
			nxt_rd_data = store_ff[OFF_GROUP_ADDR];
		end else if (rd_addr == OFF_DEST_ADDR) begin
			nxt_rd_data = store_ff[OFF_DEST_ADDR];
		end else if (rd_addr == OFF_SPECIAL) begin
			nxt_rd_data = store_ff[OFF_SPECIAL];
		// system code
		end else if (rd_addr == OFF_SYS_CODE_LOW) begin
			nxt_rd_data = store_ff[OFF_SYS_CODE_LOW];
		end else if (rd_addr == OFF_SYS_CODE_HIGH) begin
			nxt_rd_data = store_ff[OFF_SYS_CODE_HIGH];
		// radio and timing
		end else if (rd_addr == OFF_FREQ_GROUP) begin
			nxt_rd_data = store_ff[OFF_FREQ_GROUP];
		end else if (rd_addr == OFF_PKT_INTERVAL) begin
			nxt_rd_data = store_ff[OFF_PKT_INTERVAL];
		end else if (rd_addr == OFF_RSVD_EIGHT) begin
			nxt_rd_data = store_ff[OFF_RSVD_EIGHT];
		end else if (rd_addr == OFF_RSVD_NINE) begin
			nxt_rd_data = store_ff[OFF_RSVD_NINE];
		end else if (rd_addr == OFF_CMD_HEADER) begin
			nxt_rd_data = store_ff[OFF_CMD_HEADER];
		end else if (rd_addr == OFF_RETX_COUNT) begin
			nxt_rd_data = store_ff[OFF_RETX_COUNT];
		end else if (rd_addr == OFF_ROAM_THRESH) begin
			nxt_rd_data = store_ff[OFF_ROAM_THRESH];
		end else if (rd_addr == OFF_RSVD_THIRTEEN) begin
			nxt_rd_data = store_ff[OFF_RSVD_THIRTEEN];
		end else if (rd_addr == OFF_RX_OUT_GAP) begin
			nxt_rd_data = store_ff[OFF_RX_OUT_GAP];
		end else if (rd_addr == OFF_CMD_RECOG) begin
			nxt_rd_data = store_ff[OFF_CMD_RECOG];
		end else if (rd_addr == OFF_CMD_TIMEOUT) begin
			nxt_rd_data = store_ff[OFF_CMD_TIMEOUT];
		end else if (rd_addr == OFF_RSVD_SEVENTEEN) begin
			nxt_rd_data = store_ff[OFF_RSVD_SEVENTEEN];
		// link and mode settings
		end else if (rd_addr == OFF_COMM_SET_ONE) begin
			nxt_rd_data = store_ff[OFF_COMM_SET_ONE];
		end else if (rd_addr == OFF_COMM_SET_TWO) begin
			nxt_rd_data = store_ff[OFF_COMM_SET_TWO];
		end else if (rd_addr == OFF_SERIAL_ONE) begin
			nxt_rd_data = store_ff[OFF_SERIAL_ONE];
		end else if (rd_addr == OFF_SERIAL_TWO) begin
			nxt_rd_data = store_ff[OFF_SERIAL_TWO];
		end else if (rd_addr == OFF_SERIAL_THREE) begin
			nxt_rd_data = store_ff[OFF_SERIAL_THREE];
		end else if (rd_addr == OFF_SERIAL_FOUR) begin
			nxt_rd_data = store_ff[OFF_SERIAL_FOUR];
		end else if (rd_addr == OFF_MISC) begin
			nxt_rd_data = store_ff[OFF_MISC];
		end else if (rd_addr == OFF_LOW_POWER) begin
			nxt_rd_data = store_ff[OFF_LOW_POWER];
		end else if (rd_addr == OFF_RSVD_TWENTY_SIX) begin
			nxt_rd_data = store_ff[OFF_RSVD_TWENTY_SIX];
		end else if (rd_addr == OFF_BAND) begin
			nxt_rd_data = store_ff[OFF_BAND];
		end else begin
			nxt_rd_data = RD_IDLE; // RULE17
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_data_ff <= RD_IDLE;
		end else begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// ==========================================
	// field views of the active copy
	assign dest_check_on = active_ff[OFF_COMM_SET_ONE][DEST_CHECK_BIT]; // RULE16
	assign src_check_on  = active_ff[OFF_COMM_SET_ONE][SRC_CHECK_BIT];
	assign local_addr    = active_ff[OFF_LOCAL_STATION];
	assign group_addr    = active_ff[OFF_GROUP_ADDR];
	assign peer_addr     = active_ff[OFF_DEST_ADDR];

	// ==========================================
	// receive header filter
	always_comb begin
		nxt_accept  = 1'b0;
		nxt_discard = 1'b0;
		if (rx_hdr_valid) begin
			if (dest_check_on && rx_dest_addr != local_addr) begin // RULE5
				nxt_discard = 1'b1;
			end else if (src_check_on && rx_src_addr != peer_addr) begin
				nxt_discard = 1'b1;
			end else begin
				nxt_accept = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			accept_ff  <= 1'b0;
			discard_ff <= 1'b0;
		end else begin
			accept_ff  <= nxt_accept;
			discard_ff <= nxt_discard;
		end
	end

	// ==========================================
	// multidrop command address match
	always_comb begin
		nxt_cmd = 1'b0;
		if (cmd_valid) begin
			if (cmd_addr == local_addr) begin
				nxt_cmd = 1'b1; // RULE6
			end else if (cmd_addr == group_addr) begin
				nxt_cmd = 1'b1; // RULE8
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmd_ff <= 1'b0;
		end else begin
			cmd_ff <= nxt_cmd;
		end
	end

	// ==========================================
	// outputs
	assign rd_data         = rd_data_ff;
	assign rx_accept       = accept_ff;
	assign rx_discard      = discard_ff;
	assign cmd_match       = cmd_ff;
	assign tx_src_addr     = active_ff[OFF_LOCAL_STATION]; // RULE4
	assign drop_addr       = active_ff[OFF_LOCAL_STATION]; // RULE6
	assign headerless_dest = active_ff[OFF_DEST_ADDR]; // RULE9
	assign special_mode    = active_ff[OFF_SPECIAL]; // RULE10
	assign scramble_seed   = seed_ff; // RULE14
	assign load_busy       = load_now;

	for (genvar g = 0; g < NUM_REGS; g++) begin : g_flat
		assign active_cfg[g*REG_W +: REG_W] = active_ff[g];
	end
endmodule : mcrb_config_bank

// ### mcrb_host.sv
/* host model: register writes, reads and restart pulses.
   assumes the bench clock; changes its pins at falling edges only. */
`timescale 1ns/1ps
module mcrb_host (
	input  wire logic       core_clk,
	input  wire logic [7:0] rd_data,
	output logic            wr_en = 1'b0,
	output logic            soft_restart = 1'b0,
	output logic [4:0]      wr_addr = 5'h00,
	output logic [4:0]      rd_addr = 5'h00,
	output logic [7:0]      wr_data = 8'h00
);
	// ====================
	// access tasks
	// values kept in range except where a test asks otherwise
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge core_clk);
		wr_en = 1'b1;
		wr_addr = a;
		wr_data = d;
		@(negedge core_clk);
		wr_en = 1'b0;
		wr_data = ~d;
	endtask : wr
	task rd(input logic [4:0] a, output logic [7:0] d);
		@(negedge core_clk);
		rd_addr = a;
		@(negedge core_clk);
		d = rd_data;
	endtask : rd
	// copy lands one edge after the pulse is taken
	task restart;
		@(negedge core_clk);
		soft_restart = 1'b1;
		@(negedge core_clk);
		soft_restart = 1'b0;
		@(negedge core_clk);
	endtask : restart
endmodule : mcrb_host

// ### mcrb_pkg.sv
/*
 * constants for the modem configuration register bank: offsets, defaults, field positions.
 * assumes a single 10 MHz core clock and synchronous active-high reset.
 */
package mcrb_pkg;
	// ==========================================
	// geometry
	localparam int unsigned NUM_REGS   = 28;
	localparam int unsigned REG_W      = 8;
	localparam int unsigned ADDR_W     = 5;

	// ==========================================
	// offsets
	localparam logic [4:0] OFF_LOCAL_STATION   = 5'h00;
	localparam logic [4:0] OFF_GROUP_ADDR      = 5'h01;
	localparam logic [4:0] OFF_DEST_ADDR       = 5'h02;
	localparam logic [4:0] OFF_SPECIAL         = 5'h03;
	localparam logic [4:0] OFF_SYS_CODE_LOW    = 5'h04;
	localparam logic [4:0] OFF_SYS_CODE_HIGH   = 5'h05;
	localparam logic [4:0] OFF_FREQ_GROUP      = 5'h06;
	localparam logic [4:0] OFF_PKT_INTERVAL    = 5'h07;
	localparam logic [4:0] OFF_RSVD_EIGHT      = 5'h08;
	localparam logic [4:0] OFF_RSVD_NINE       = 5'h09;
	localparam logic [4:0] OFF_CMD_HEADER      = 5'h0A;
	localparam logic [4:0] OFF_RETX_COUNT      = 5'h0B;
	localparam logic [4:0] OFF_ROAM_THRESH     = 5'h0C;
	localparam logic [4:0] OFF_RSVD_THIRTEEN   = 5'h0D;
	localparam logic [4:0] OFF_RX_OUT_GAP      = 5'h0E;
	localparam logic [4:0] OFF_CMD_RECOG       = 5'h0F;
	localparam logic [4:0] OFF_CMD_TIMEOUT     = 5'h10;
	localparam logic [4:0] OFF_RSVD_SEVENTEEN  = 5'h11;
	localparam logic [4:0] OFF_COMM_SET_ONE    = 5'h12;
	localparam logic [4:0] OFF_COMM_SET_TWO    = 5'h13;
	localparam logic [4:0] OFF_SERIAL_ONE      = 5'h14;
	localparam logic [4:0] OFF_SERIAL_TWO      = 5'h15;
	localparam logic [4:0] OFF_SERIAL_THREE    = 5'h16;
	localparam logic [4:0] OFF_SERIAL_FOUR     = 5'h17;
	localparam logic [4:0] OFF_MISC            = 5'h18;
	localparam logic [4:0] OFF_LOW_POWER       = 5'h19;
	localparam logic [4:0] OFF_RSVD_TWENTY_SIX = 5'h1A;
	localparam logic [4:0] OFF_BAND            = 5'h1B;
	localparam logic [4:0] OFF_LAST            = 5'h1B;

	// readback value after reset and for unmapped offsets
	localparam logic [7:0] RD_IDLE             = 8'h00;

	// ==========================================
	// field positions and clamp values
	localparam int unsigned DEST_CHECK_BIT     = 0;
	localparam int unsigned SRC_CHECK_BIT      = 1;
	localparam logic [7:0] CODE_HIGH_LIMIT     = 8'hF0;
	localparam logic [7:0] CODE_LOW_CLAMP      = 8'hFF;
	localparam logic [7:0] CODE_HIGH_CLAMP     = 8'hEF;

	// ==========================================
	// reset values, index = offset
	localparam logic [7:0] REG_DEFAULT [NUM_REGS] = '{
		8'h00, 8'hF0, 8'h00, 8'hF0, 8'h00, 8'h00, 8'hA0, 8'h05,
		8'h11, 8'h13, 8'h40, 8'h32, 8'hB4, 8'h1E, 8'h00, 8'h00,
		8'h32, 8'h32, 8'h8C, 8'h00, 8'h05, 8'h09, 8'h00, 8'h00,
		8'hC0, 8'h40, 8'h00, 8'h00
	};

	// reserved registers ignore writes
	localparam logic [NUM_REGS-1:0] RSVD_MASK = 28'h4022300;

	// ==========================================
	// load sequencer
	typedef enum logic [0:0] {
		MCRB_RUN  = 1'b0,
		MCRB_LOAD = 1'b1
	} mcrb_state_e;
endpackage : mcrb_pkg

// ### tb.sv
/* bench: defaults, reserved writes, restart, address filters and code clamp.
   assumes the package, bank, host model and checker are compiled first. */
`timescale 1ns/1ps
module tb;
	import mcrb_pkg::*;
	logic         core_clk = 1'b0, reset = 1'b1, rx_hdr_valid = 1'b0, cmd_valid = 1'b0;
	logic         wr_en, soft_restart, rx_accept, rx_discard, cmd_match, load_busy;
	logic [4:0]   wr_addr, rd_addr;
	logic [7:0]   wr_data, rd_data, tx_src_addr, drop_addr, headerless_dest, special_mode, v;
	logic [7:0]   rx_dest_addr = 8'h00, cmd_addr = 8'h00;
	logic [15:0]  scramble_seed;
	logic [223:0] active_cfg;
	int           num_errors = 0, n_compared = 0;
	always #50 core_clk = ~core_clk;
	mcrb_config_bank dut_u (.*, .rx_src_addr(8'h00));
	mcrb_host host_u (.*);
	// ====================
	// checks and closing
	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task final_report;
		if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : final_report
	task hdr(input logic [7:0] d, input logic [2:0] exp);
		@(negedge core_clk);
		{rx_dest_addr, cmd_addr, rx_hdr_valid, cmd_valid} = {d, d, 2'h3};
		@(negedge core_clk);
		{rx_hdr_valid, cmd_valid} = 2'h0;
		check({13'h0, rx_accept, rx_discard, cmd_match}, {13'h0, exp});
	endtask : hdr
	initial begin
		#200000 num_errors++;
		final_report;
	end
	initial begin
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		for (int i = 0; i < 28; i++) begin
			host_u.rd(i[4:0], v);
			check(v, REG_DEFAULT[i]);
		end
		for (int i = 0; i < 32; i++) host_u.wr(i[4:0], 8'h5A);
		for (int i = 0; i < 32; i++) begin
			host_u.rd(i[4:0], v);
			check(v, i > 27 ? 8'h00 : RSVD_MASK[i] ? REG_DEFAULT[i] : 8'h5A);
		end
		check({tx_src_addr, active_cfg[15:8]}, 16'h00F0);
		host_u.wr(OFF_LOCAL_STATION, 8'h05);
		host_u.wr(OFF_GROUP_ADDR, 8'hF3);
		host_u.wr(OFF_DEST_ADDR, 8'h22);
		host_u.wr(OFF_SPECIAL, 8'hF1);
		host_u.wr(OFF_SYS_CODE_LOW, 8'h34);
		host_u.wr(OFF_SYS_CODE_HIGH, 8'h12);
		host_u.wr(OFF_COMM_SET_ONE, 8'h01);
		host_u.restart;
		check({tx_src_addr, drop_addr}, 16'h0505);
		check({headerless_dest, special_mode}, 16'h22F1);
		check(scramble_seed, 16'h1234);
		hdr(8'h05, 3'h5);
		hdr(8'h06, 3'h2);
		hdr(8'hF3, 3'h3);
		host_u.wr(OFF_SYS_CODE_HIGH, 8'hF0);
		host_u.restart;
		check(scramble_seed, 16'hEFFF);
		reset = 1'b1;
		repeat (8) @(negedge core_clk);
		reset = 1'b0;
		host_u.rd(OFF_LOCAL_STATION, v);
		check({tx_src_addr, v}, 16'h0000);
		final_report;
	end
endmodule : tb
bind mcrb_config_bank mcrb_chk chk_u (.*);
